// ==== include/bip_pkg.sv ====
package bip_pkg;
    localparam int NSRC = 23;
    localparam int NLVL = 12;
    localparam int RW   = 4;
    localparam int AW   = 8;

    // level codes carried on the jumper route inputs
    localparam logic [3:0] ROUTE_RES0 = 4'h4;
    localparam logic [3:0] ROUTE_NONE = 4'hF;

    // fixed call addresses of the processor-level inputs: top, high, middle, low
    localparam logic [15:0] CPU_ADDR [0:3] = '{16'h0024, 16'h003C, 16'h0034, 16'h002C};
    localparam logic [2:0]  SRC_RES = 3'h4;

    // register offsets (byte addresses)
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_MASK = 8'h04;
    localparam logic [AW-1:0] OFS_BASE = 8'h08;
    localparam logic [AW-1:0] OFS_STAT = 8'h0C;
    localparam logic [AW-1:0] OFS_POLL = 8'h10;
    localparam logic [AW-1:0] OFS_EOI  = 8'h14;

    // field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_SP8_BIT   = 2;
    localparam int CTRL_LOW_LSB   = 4;
    localparam int CTRL_CMASK_LSB = 8;
    localparam int STAT_ISR_LSB   = 8;
    localparam int STAT_CPU_LSB   = 16;
    localparam int POLL_VLD_BIT   = 7;

    // reset values
    localparam logic [7:0]  RST_MASK  = 8'h00;
    localparam logic [15:0] RST_BASE  = 16'h0000;
    localparam logic [2:0]  RST_CMASK = 3'h0;
    localparam logic [2:0]  RST_LOW   = 3'h7;

    typedef enum logic [1:0] {
        MODE_NESTED   = 2'h0,
        MODE_ROTATE   = 2'h1,
        MODE_SPECIFIC = 2'h2,
        MODE_POLLED   = 2'h3
    } bip_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_CALL = 2'h2
    } bip_call_type;

    // distance of a level below the current top-priority level
    function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] b);
        return lvl - b;
    endfunction

    // first set bit walking upward from the top-priority level
    function automatic logic [2:0] pick(input logic [7:0] v, input logic [2:0] b);
        logic [2:0] k;
        logic [2:0] res;
        res = b;
        for (int i = 7; i >= 0; i--) begin
            k = b + 3'(i);
            if (v[k]) res = k;
        end
        return res;
    endfunction

    function automatic logic [15:0] vec_addr(input logic [15:0] base, input logic [2:0] lvl,
                                             input logic sp8);
        return sp8 ? {base[15:6], lvl, 3'h0} : {base[15:5], lvl, 2'h0};
    endfunction
endpackage

// ==== include/bip_res_if.sv ====
`timescale 1ns/1ps
interface bip_res_if;
    logic [7:0]           req;
    logic [7:0]           mask;
    bip_pkg::bip_mode_type mode;
    logic [2:0]           lowest;
    logic                 ack;
    logic [2:0]           ack_lvl;
    logic                 eoi;
    logic                 poll;
    logic                 int_valid;
    logic [2:0]           int_level;
    logic                 any_pend;
    logic [7:0]           irr;
    logic [7:0]           isr;

    modport ctl (output req, mask, mode, lowest, ack, ack_lvl, eoi, poll,
                 input int_valid, int_level, any_pend, irr, isr);
    modport res (input req, mask, mode, lowest, ack, ack_lvl, eoi, poll,
                 output int_valid, int_level, any_pend, irr, isr);
endinterface

// ==== rtl/bip_resolver.sv ====
`timescale 1ns/1ps
module bip_resolver (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control side
    bip_res_if.res   r
);
    logic [7:0] irr_r;
    logic [7:0] isr_r;
    logic [2:0] rot_r;
    logic [2:0] base;
    logic [7:0] pend;
    logic [2:0] top_pend;
    logic [2:0] top_isr;
    logic [7:0] take;
    logic [7:0] done;

    always_comb begin
        unique case (r.mode)
            bip_pkg::MODE_ROTATE:   base = rot_r; // [R10]
            bip_pkg::MODE_SPECIFIC: base = r.lowest + 3'h1; // [R11]
            default:                base = 3'h0; // [R9]
        endcase
    end

    assign pend     = irr_r & ~r.mask; // [R6]
    assign top_pend = bip_pkg::pick(pend, base);
    assign top_isr  = bip_pkg::pick(isr_r, base);
    assign r.any_pend  = |pend;
    assign r.int_level = top_pend;
    // outranking the level in service; polled mode never calls
    assign r.int_valid = (|pend) && (r.mode != bip_pkg::MODE_POLLED) && // [R12]
                         (isr_r == 8'h00 || bip_pkg::rank(top_pend, base) < bip_pkg::rank(top_isr, base)); // [R5]
    assign take = r.ack ? (8'h01 << r.ack_lvl) : (r.poll && (|pend)) ? (8'h01 << top_pend) : 8'h00;
    assign done = (r.eoi && isr_r != 8'h00) ? (8'h01 << top_isr) : 8'h00;
    assign r.irr = irr_r;
    assign r.isr = isr_r;

    // new request wins over the clear of the same level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irr_r <= 8'h00;
        else irr_r <= (irr_r & ~take) | r.req;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) isr_r <= 8'h00;
        else isr_r <= (isr_r & ~done) | take;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rot_r <= 3'h0;
        else if (r.eoi && isr_r != 8'h00 && r.mode == bip_pkg::MODE_ROTATE) rot_r <= top_isr + 3'h1; // [R10]
    end

    a_nested_fixed: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        (r.mode == bip_pkg::MODE_NESTED && isr_r == 8'h00 && pend[0]) |-> r.int_valid && r.int_level == 3'h0)
        else $error("nested mode did not favour level zero");
    a_rotate_low: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        (r.mode == bip_pkg::MODE_ROTATE && r.eoi && isr_r != 8'h00) |=> rot_r == $past(top_isr) + 3'h1)
        else $error("serviced level not made lowest");
    a_mask_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        r.int_valid |-> !r.mask[r.int_level] && irr_r[r.int_level])
        else $error("masked level raised a call");
    a_poll_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        r.mode == bip_pkg::MODE_POLLED |-> !r.int_valid)
        else $error("polled mode issued a call");
    a_outrank_only: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        (isr_r[base] && r.mode != bip_pkg::MODE_POLLED) |-> !r.int_valid)
        else $error("call while top level in service");
endmodule // bip_resolver

// ==== rtl/bip_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [R1] twelve vectored levels: four processor-level, eight through the priority resolver
// [R2] processor levels ranked top, high restart, middle restart, low restart
// [R3] each processor level calls its own fixed address
// [R4] all processor levels maskable except the non-maskable top request
// [R5] resolver calls only when best pending outranks level in service
// [R6] one byte write masks any combination of the eight resolver levels
// [R7] distinct resolver vectors, spaced four or eight bytes by software
// [R8] vector block of 32 or 64 bytes on any matching boundary
// [R9] fully nested: level zero highest, level seven lowest
// [R10] autorotating: serviced level drops to lowest priority
// [R11] specific priority: software names the lowest level, others follow numerically
// [R12] polled: encoded status read from a register instead of a call
// [R13] up to twenty-three request sources, each routed to a level
// [R14] each expansion module drives two request lines
// [R15] parallel ports request on input full and on output taken
// [R16] serial transceiver gives receive full, transmit ready, transmit empty
// [R17] each timer output may serve as one request source
// [R18] nine system-bus request lines accepted as sources
// [R19] mains-low warning usable as an interrupt source
// [R20] source routing is a static input sampled only at reset
module bip_top (
    // apb
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [bip_pkg::AW-1:0]     paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // request sources
    input  wire logic [1:0]                 pp_in_full,
    input  wire logic [1:0]                 pp_out_empty,
    input  wire logic                       ser_rx_full,
    input  wire logic                       ser_tx_ready,
    input  wire logic                       ser_tx_empty,
    input  wire logic [1:0]                 tmr_out,
    input  wire logic [3:0]                 exp_irq,
    input  wire logic [8:0]                 bus_irq,
    input  wire logic                       mains_low_warning,
    // static routing, four bits per source
    input  wire logic [bip_pkg::NSRC*bip_pkg::RW-1:0] jumper_route,
    // processor call port
    output logic                            call_valid,
    output logic [15:0]                     call_addr,
    input  wire logic                       call_taken
);
    bip_res_if ri ();

    logic [bip_pkg::NSRC-1:0]         src;
    logic [bip_pkg::NSRC*bip_pkg::RW-1:0] route_r;
    logic                             route_taken_r;
    logic [bip_pkg::NLVL-1:0]         lvl_req;
    logic [3:0]                       cpu_pend_r;
    logic [3:0]                       cpu_go;
    logic [3:0]                       cpu_clr;
    bip_pkg::bip_mode_type            mode_r;
    logic                             sp8_r;
    logic [2:0]                       low_r;
    logic [2:0]                       cmask_r;
    logic [7:0]                       mask_r;
    logic [15:0]                      base_r;
    bip_pkg::bip_call_type            st_r;
    logic                             call_valid_r;
    logic [15:0]                      call_addr_r;
    logic [2:0]                       call_src_r;
    logic [2:0]                       call_lvl_r;
    logic                             sel_ok;
    logic [2:0]                       sel_src;
    logic [15:0]                      sel_addr;
    logic [31:0]                      prdata_r;
    logic                             pready_r;
    logic                             pslverr_r;
    logic                             access;
    logic                             xfer;
    logic                             wr_xfer;
    logic                             mapped;
    logic [31:0]                      rd_val;

    // request sources, one bit each
    assign src = {mains_low_warning, // [R19]
                  bus_irq, // [R18]
                  exp_irq, // [R14]
                  tmr_out, // [R17]
                  ser_tx_empty, ser_tx_ready, ser_rx_full, // [R16]
                  pp_out_empty, pp_in_full}; // [R15]

    // routing is caught once after reset release; later jumper changes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_r       <= {bip_pkg::NSRC{bip_pkg::ROUTE_NONE}};
            route_taken_r <= 1'b0;
        end else if (!route_taken_r) begin
            route_r       <= jumper_route; // [R20]
            route_taken_r <= 1'b1;
        end
    end

    // several sources may share a level; they are or-ed
    always_comb begin
        lvl_req = '0;
        for (int i = 0; i < bip_pkg::NSRC; i++) begin
            if (route_r[i*bip_pkg::RW +: bip_pkg::RW] < 4'(bip_pkg::NLVL)) // [R13]
                lvl_req[route_r[i*bip_pkg::RW +: bip_pkg::RW]] = lvl_req[route_r[i*bip_pkg::RW +: bip_pkg::RW]] | src[i];
        end
    end

    // processor-level latches; an arriving request beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cpu_pend_r <= 4'h0;
        else cpu_pend_r <= (cpu_pend_r & ~cpu_clr) | lvl_req[3:0]; // [R1]
    end

    assign cpu_go  = cpu_pend_r & {~cmask_r[2], ~cmask_r[1], ~cmask_r[0], 1'b1}; // [R4]
    assign cpu_clr = (st_r == bip_pkg::ST_CALL && call_taken && call_src_r != bip_pkg::SRC_RES)
                     ? (4'h1 << call_src_r[1:0]) : 4'h0;

    // resolver hookup
    assign ri.req     = lvl_req[bip_pkg::NLVL-1:bip_pkg::ROUTE_RES0]; // [R1]
    assign ri.mask    = mask_r;
    assign ri.mode    = mode_r;
    assign ri.lowest  = low_r;
    assign ri.ack     = st_r == bip_pkg::ST_CALL && call_taken && call_src_r == bip_pkg::SRC_RES;
    assign ri.ack_lvl = call_lvl_r;
    assign ri.eoi     = wr_xfer && paddr == bip_pkg::OFS_EOI;
    assign ri.poll    = xfer && !pwrite && paddr == bip_pkg::OFS_POLL && mode_r == bip_pkg::MODE_POLLED; // [R12]

    bip_resolver u_res (
        .pclk    (pclk),
        .presetn (presetn),
        .r       (ri)
    );

    // fixed ranking, lowest index first; resolver only when no unmasked processor level is pending
    always_comb begin
        sel_ok   = 1'b0;
        sel_src  = bip_pkg::SRC_RES;
        sel_addr = bip_pkg::vec_addr(base_r, ri.int_level, sp8_r); // [R7] [R8]
        if (ri.int_valid) sel_ok = 1'b1;
        for (int i = 3; i >= 0; i--) begin
            if (cpu_go[i]) begin // [R2]
                sel_ok   = 1'b1;
                sel_src  = 3'(i);
                sel_addr = bip_pkg::CPU_ADDR[i]; // [R3]
            end
        end
    end

    // call handshake: a call is held until the processor takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= bip_pkg::ST_IDLE;
        end else begin
            unique case (st_r)
                bip_pkg::ST_IDLE: if (sel_ok) st_r <= bip_pkg::ST_CALL;
                bip_pkg::ST_CALL: if (call_taken) st_r <= bip_pkg::ST_IDLE;
                default:          st_r <= bip_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_valid_r <= 1'b0;
            call_addr_r  <= 16'h0000;
            call_src_r   <= bip_pkg::SRC_RES;
            call_lvl_r   <= 3'h0;
        end else if (st_r == bip_pkg::ST_IDLE && sel_ok) begin
            call_valid_r <= 1'b1;
            call_addr_r  <= sel_addr;
            call_src_r   <= sel_src;
            call_lvl_r   <= ri.int_level;
        end else if (st_r == bip_pkg::ST_CALL && call_taken) begin
            call_valid_r <= 1'b0;
        end
    end

    assign call_valid = call_valid_r;
    assign call_addr  = call_addr_r;

    // apb: pready one cycle after the access phase opens; effects at the completing edge
    assign access  = psel && penable && !pready_r;
    assign xfer    = psel && penable && pready_r;
    assign wr_xfer = xfer && pwrite && !pslverr_r;
    assign mapped  = paddr == bip_pkg::OFS_CTRL || paddr == bip_pkg::OFS_MASK || paddr == bip_pkg::OFS_BASE ||
                     paddr == bip_pkg::OFS_STAT || paddr == bip_pkg::OFS_POLL || paddr == bip_pkg::OFS_EOI;

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (paddr)
            bip_pkg::OFS_CTRL: begin
                rd_val[bip_pkg::CTRL_MODE_LSB +: 2]  = mode_r;
                rd_val[bip_pkg::CTRL_SP8_BIT]        = sp8_r;
                rd_val[bip_pkg::CTRL_LOW_LSB +: 3]   = low_r;
                rd_val[bip_pkg::CTRL_CMASK_LSB +: 3] = cmask_r;
            end
            bip_pkg::OFS_MASK: rd_val[7:0]  = mask_r;
            bip_pkg::OFS_BASE: rd_val[15:0] = base_r;
            bip_pkg::OFS_STAT: begin
                rd_val[7:0]                        = ri.irr;
                rd_val[bip_pkg::STAT_ISR_LSB +: 8] = ri.isr;
                rd_val[bip_pkg::STAT_CPU_LSB +: 4] = cpu_pend_r;
            end
            bip_pkg::OFS_POLL: begin
                rd_val[bip_pkg::POLL_VLD_BIT] = ri.any_pend; // [R12]
                rd_val[2:0]                   = ri.int_level;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= access;
            pslverr_r <= access && !mapped;
            if (access && !pwrite) prdata_r <= rd_val;
        end
    end

    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r  <= bip_pkg::MODE_NESTED;
            sp8_r   <= 1'b0;
            low_r   <= bip_pkg::RST_LOW;
            cmask_r <= bip_pkg::RST_CMASK;
        end else if (wr_xfer && paddr == bip_pkg::OFS_CTRL) begin
            mode_r  <= bip_pkg::bip_mode_type'(pwdata[bip_pkg::CTRL_MODE_LSB +: 2]); // [R9] [R10] [R11] [R12]
            sp8_r   <= pwdata[bip_pkg::CTRL_SP8_BIT]; // [R7]
            low_r   <= pwdata[bip_pkg::CTRL_LOW_LSB +: 3]; // [R11]
            cmask_r <= pwdata[bip_pkg::CTRL_CMASK_LSB +: 3]; // [R4]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mask_r <= bip_pkg::RST_MASK;
        else if (wr_xfer && paddr == bip_pkg::OFS_MASK) mask_r <= pwdata[7:0]; // [R6]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) base_r <= bip_pkg::RST_BASE;
        else if (wr_xfer && paddr == bip_pkg::OFS_BASE) base_r <= pwdata[15:0]; // [R8]
    end

    sequence s_access;
        psel && penable && !pready_r;
    endsequence

    sequence s_open(logic [2:0] s);
        st_r == bip_pkg::ST_IDLE && sel_ok && sel_src == s;
    endsequence

    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        s_access |=> pready_r)
        else $error("apb access not answered next cycle");
    a_trap_first: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        (st_r == bip_pkg::ST_IDLE && cpu_pend_r[0]) |=> call_valid_r && call_src_r == 3'h0)
        else $error("top request not called first");
    a_fixed_addr: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        s_open(3'h2) |=> call_valid_r && call_addr_r == 16'h0034)
        else $error("middle restart call address wrong");
    a_mask_cpu: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        (st_r == bip_pkg::ST_IDLE && !cpu_pend_r[0] && (cpu_pend_r[3:1] & ~cmask_r) == 3'h0 && !ri.int_valid) |=> !call_valid_r)
        else $error("masked restart level called");
    a_vec_block: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        s_open(bip_pkg::SRC_RES) |=> call_addr_r[15:6] == $past(base_r[15:6]) &&
                                     (call_addr_r[5] == $past(base_r[5]) || $past(sp8_r)))
        else $error("resolver vector outside its block");
    a_vec_space: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        s_open(bip_pkg::SRC_RES) |=> ($past(sp8_r) ? call_addr_r[5:3] : call_addr_r[4:2]) == call_lvl_r)
        else $error("resolver vector spacing wrong");
    a_call_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        (call_valid_r && !call_taken) |=> call_valid_r && $stable(call_addr_r))
        else $error("call dropped before taken");
    a_route_once: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
        route_taken_r |=> route_taken_r && $stable(route_r))
        else $error("routing changed after reset");
    a_src_route: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (route_taken_r && route_r[bip_pkg::RW-1:0] == 4'h0 && src[0]) |=> cpu_pend_r[0])
        else $error("routed source did not raise its level");
endmodule // bip_top

// ==== dv/bip_cpu_model.sv ====
`timescale 1ns/1ps
module bip_cpu_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // call port
    input  wire logic call_valid,
    output logic      call_taken
);
    logic [1:0] wait_r;
    logic       slow_r;
    // alternate prompt and slow takes so both latencies are seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_taken <= 1'b0;
            wait_r     <= 2'h0;
            slow_r     <= 1'b0;
        end else if (call_taken) begin
            call_taken <= 1'b0;
            wait_r     <= 2'h0;
            slow_r     <= !slow_r;
        end else if (call_valid) begin
            wait_r     <= wait_r + 2'h1;
            call_taken <= !slow_r || wait_r == 2'h3;
        end
    end
endmodule // bip_cpu_model

// ==== dv/board_interrupt_prioritizer_bench.sv ====
`timescale 1ns/1ps
module board_interrupt_prioritizer_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, call_valid, call_taken, sp8;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] call_addr, base;
    logic [22:0] src;
    logic [91:0] route;
    logic [33:0] ap_q[$];
    logic [15:0] call_q[$];
    int          n_fail, total_checks, seed;

    bip_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pp_in_full(src[1:0]), .pp_out_empty(src[3:2]), .ser_rx_full(src[4]), .ser_tx_ready(src[5]),
        .ser_tx_empty(src[6]), .tmr_out(src[8:7]), .exp_irq(src[12:9]), .bus_irq(src[21:13]),
        .mains_low_warning(src[22]), .jumper_route(route), .call_valid(call_valid),
        .call_addr(call_addr), .call_taken(call_taken));
    bip_cpu_model cpu (.pclk(pclk), .presetn(presetn), .call_valid(call_valid), .call_taken(call_taken));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic report(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_apb(input logic [33:0] e);
        report({e[33], pslverr, e[33] ? prdata : e[31:0]}, e);
    endtask
    // a call with nothing noted is forced to mismatch
    task automatic cmp_call(input logic [15:0] got);
        logic        stray;
        logic [15:0] e;
        stray = call_q.size() == 0;
        e     = stray ? ~got : call_q.pop_front();
        report({18'h0, got}, {18'h0, e});
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) cmp_apb(ap_q.pop_front());
        if (call_valid === 1'b1 && call_taken === 1'b1) cmp_call(call_addr);
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic chk, input logic err);
        ap_q.push_back({chk, err, d});
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= w ? d : 32'($random(seed));
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic ctl(input logic [1:0] mode, input logic [2:0] low);
        apb(1'b1, bip_pkg::OFS_CTRL, {25'h0, low, 1'b0, sp8, mode}, 1'b0, 1'b0);
    endtask
    task automatic eoi;
        apb(1'b1, bip_pkg::OFS_EOI, 32'h0, 1'b0, 1'b0);
    endtask
    task automatic pulse(input logic [22:0] m);
        src <= m;
        @(posedge pclk);
        src <= 23'h0;
        @(posedge pclk);
    endtask
    // waits for every noted call, then leaves room for a stray one to show
    task automatic drain;
        for (int i = 0; i < 200 && call_q.size() != 0; i++) @(posedge pclk);
        repeat (8) @(posedge pclk);
        if (call_q.size() != 0) begin
            n_fail++;
            $display("Error at %0t: %0d expected calls missing", $time, call_q.size());
            call_q.delete();
        end
    endtask
    task automatic exp_lvl(input logic [2:0] l);
        call_q.push_back(sp8 ? {base[15:6], l, 3'h0} : {base[15:5], l, 2'h0});
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #80000;
        n_fail++;
        finish_test;
    end

    initial begin
        seed = 72451;
        {presetn, psel, penable, pwrite, paddr, pwdata, src, sp8, base, n_fail, total_checks} = '0;
        route = {92{1'b1}};
        for (int i = 1; i < 12; i++) route[4*i+:4] = 4'(i);
        route[55:52] = 4'h8;
        route[91:88] = 4'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        // jumpers pulled away after reset: every later call proves the routing was kept
        route   <= {92{1'b1}};
        apb(1'b0, bip_pkg::OFS_CTRL, {21'h0, bip_pkg::RST_CMASK, 1'b0, bip_pkg::RST_LOW, 4'h0}, 1'b1, 1'b0);
        apb(1'b0, bip_pkg::OFS_MASK, {24'h0, bip_pkg::RST_MASK}, 1'b1, 1'b0);
        apb(1'b0, bip_pkg::OFS_BASE, {16'h0, bip_pkg::RST_BASE}, 1'b1, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 1'b0, 1'b1);
        // three restart levels masked, only the top request gets through
        apb(1'b1, bip_pkg::OFS_CTRL, 32'h0000_0770, 1'b0, 1'b0);
        call_q.push_back(bip_pkg::CPU_ADDR[0]);
        pulse(23'h40000E);
        drain;
        for (int i = 1; i < 4; i++) call_q.push_back(bip_pkg::CPU_ADDR[i]);
        ctl(2'h0, 3'h7);
        drain;
        for (int k = 0; k < 2; k++) begin
            base = 16'($random(seed));
            sp8  = k[0];
            apb(1'b1, bip_pkg::OFS_BASE, {16'h0, base}, 1'b0, 1'b0);
            ctl(2'h0, 3'h7);
            exp_lvl(3'h2);
            pulse(23'h240);
            drain;
            exp_lvl(3'h5);
            eoi;
            drain;
            eoi;
        end
        apb(1'b1, bip_pkg::OFS_MASK, 32'h01, 1'b0, 1'b0);
        pulse(23'h10);
        drain;
        exp_lvl(3'h0);
        apb(1'b1, bip_pkg::OFS_MASK, 32'h00, 1'b0, 1'b0);
        drain;
        eoi;
        ctl(2'h1, 3'h7);
        exp_lvl(3'h3);
        pulse(23'h80);
        drain;
        eoi;
        exp_lvl(3'h4);
        pulse(23'h2010);
        drain;
        exp_lvl(3'h0);
        eoi;
        drain;
        eoi;
        ctl(2'h2, 3'h5);
        exp_lvl(3'h7);
        pulse(23'h840);
        drain;
        exp_lvl(3'h2);
        eoi;
        drain;
        eoi;
        ctl(2'h3, 3'h7);
        pulse(23'h400);
        drain;
        apb(1'b0, bip_pkg::OFS_STAT, 32'h0000_0040, 1'b1, 1'b0);
        apb(1'b0, bip_pkg::OFS_POLL, 32'h0000_0086, 1'b1, 1'b0);
        apb(1'b0, bip_pkg::OFS_STAT, 32'h0000_4000, 1'b1, 1'b0);
        eoi;
        drain;
        finish_test;
    end
endmodule // board_interrupt_prioritizer_bench
